/* File: hw/pmcap_cfg.svh */
// constants for the power-management capability register bank
// assumes an AXI4-Lite host with word-aligned accesses
// What this block does
// - capability bits 8:6 read zero
// - capability bit 5 reads zero
// - bit 4 flags cold wake needs aux
// - aux bit zero when cold wake clear
// - bit 3 set if wake needs clock
// - bit 3 zero if no wake anywhere
// - capability bits 2:0 read 010b
// - control/status survives D3hot-to-D0 reset
// - D3hot-to-D0 write raises a one-cycle func_reset_pulse
// - wake status sets on event, ignoring enable
// - write one clears status, zero ignored
// - data scale bits 14:13 read zero
// - data select bits 12:9 read zero
// - wake enable gates wake assertion
// - wake enable cleared by global reset only
// - control/status bits 7:2 read zero
// - power state field reads/writes D0..D3hot
// - cold wake bit defaults one, writable
// - capability bits 14:11 read one
`ifndef PMCAP_CFG_SVH
`define PMCAP_CFG_SVH

// register indices; byte address is four times the index
`define PMCAP_IDX_CAP 10'h0a2
`define PMCAP_IDX_CSR 10'h0a4

// capability fields
`define PMCAP_CAP_COLD_BIT 15
`define PMCAP_CAP_HOT_WAKE 4'hf
`define PMCAP_CAP_D2_D1 2'h3
`define PMCAP_CAP_VERSION 3'h2
`define PMCAP_AUX_SUPPLY 1'h1
`define PMCAP_WAKE_CLOCK 1'h0
`define PMCAP_COLD_RESET 1'h1

// control/status fields
`define PMCAP_CSR_STAT_BIT 15
`define PMCAP_CSR_EN_BIT 8
`define PMCAP_CSR_PS_LSB 0

// axi answers
`define PMCAP_RESP_OKAY 2'h0
`define PMCAP_RESP_SLVERR 2'h2

`endif

/* File: hw/pmcap_pkg.sv */
// types for the power-management capability register bank
// assumes pmcap_cfg.svh holds the numeric constants
package pmcap_pkg;

	typedef enum logic [1:0] {
		PMCAP_D0 = 2'b00,
		PMCAP_D1 = 2'b01,
		PMCAP_D2 = 2'b10,
		PMCAP_D3HOT = 2'b11
	} pmcap_pstate_e;

	typedef struct packed {
		logic aw_held;
		logic [9:0] aw_idx;
		logic w_held;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		pmcap_pstate_e power_state_field;
		logic wake_enable;
		logic wake_status_flag;
		logic cold_wake_cap;
		logic func_reset;
		logic wake_n;
		logic aw_open;
		logic w_open;
		logic ar_open;
	} pmcap_state_s;

	typedef struct packed {
		logic [15:0] data;
		logic [1:0] strb;
	} pmcap_wr_s;

endpackage

/* File: hw/pmcap_regs.sv */
// power-management capability and control/status registers
// assumes AXI4-Lite master, global reset on aresetn, card reset in
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "pmcap_cfg.svh"

module pmcap_regs
	import pmcap_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic card_bus_reset_n,
	input wire logic wake_event,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [1:0] power_state,
	output logic wake_n,
	output logic func_reset_pulse
);

	// whole block state lives in one register
	pmcap_state_s st_ff;
	pmcap_state_s nxt_st;

	// read images of the two registers
	logic [15:0] cap_word;
	logic [15:0] csr_word;

	// capability helpers
	logic hot_wake_any;
	logic any_wake;
	logic aux_bit;
	logic clk_bit;

	// write channel handshake
	logic aw_take;
	logic w_take;
	logic do_write;
	logic b_done;

	// write decode
	logic hit_cap;
	logic hit_csr;
	logic aw_hit_any;
	logic [1:0] wr_resp;

	// write strobes per register and lane
	pmcap_wr_s wr;
	logic wr_hi;
	logic wr_lo;
	logic cap_wr;
	logic csr_hi_wr;
	logic csr_lo_wr;

	// write channel next values
	logic aw_held_next;
	logic w_held_next;
	logic bvalid_next;

	// read channel
	logic [9:0] ar_idx;
	logic ar_take;
	logic r_done;
	logic ar_hit_cap;
	logic ar_hit_csr;

	// read answer
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic rvalid_next;

	// power state
	pmcap_pstate_e new_ps;
	pmcap_pstate_e ps_written;
	pmcap_pstate_e ps_next;
	logic from_d3hot;
	logic to_d0;
	logic d3hot_exit;
	logic pulse_next;

	// wake context
	logic cold_next;
	logic en_next;
	logic stat_clr;
	logic stat_kept;
	logic stat_next;
	logic card_rst;
	logic wake_drive;

	// warm wake support is fixed by the constant mask
	assign hot_wake_any = |`PMCAP_CAP_HOT_WAKE;

	// wake possible from at least one state
	assign any_wake = st_ff.cold_wake_cap | hot_wake_any;

	// aux indication only means something with cold wake
	assign aux_bit = `PMCAP_AUX_SUPPLY & st_ff.cold_wake_cap;

	// no wake support anywhere forces the clock bit low
	assign clk_bit = `PMCAP_WAKE_CLOCK & any_wake;

	// capability image
	always_comb begin
		cap_word = 16'h0000;
		cap_word[15] = st_ff.cold_wake_cap;
		cap_word[14:11] = `PMCAP_CAP_HOT_WAKE;
		cap_word[10:9] = `PMCAP_CAP_D2_D1;
		cap_word[8:6] = 3'h0;
		cap_word[5] = 1'h0;
		cap_word[4] = aux_bit;
		cap_word[3] = clk_bit;
		cap_word[2:0] = `PMCAP_CAP_VERSION;
	end

	// control/status image
	always_comb begin
		csr_word = 16'h0000;
		csr_word[`PMCAP_CSR_STAT_BIT] = st_ff.wake_status_flag;
		csr_word[14:13] = 2'h0;
		csr_word[12:9] = 4'h0;
		csr_word[`PMCAP_CSR_EN_BIT] = st_ff.wake_enable;
		csr_word[7:2] = 6'h00;
		csr_word[1:0] = st_ff.power_state_field;
	end

	// address handed over at this edge
	assign aw_take = s_axi_awvalid & st_ff.aw_open;

	// data handed over at this edge, in either order
	assign w_take = s_axi_wvalid & st_ff.w_open;

	// both halves held and no answer still waiting
	assign do_write = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;

	// answer accepted by the master
	assign b_done = st_ff.bvalid & s_axi_bready;

	// decode of the held write index
	assign hit_cap = st_ff.aw_idx == `PMCAP_IDX_CAP;
	assign hit_csr = st_ff.aw_idx == `PMCAP_IDX_CSR;
	assign aw_hit_any = hit_cap | hit_csr;

	// unmapped writes are answered but change nothing
	assign wr_resp = aw_hit_any ? `PMCAP_RESP_OKAY :
		`PMCAP_RESP_SLVERR;

	// held data and byte lanes
	assign wr.data = st_ff.wdata;
	assign wr.strb = st_ff.wstrb;

	// upper lane carries status, enable and cold wake
	assign wr_hi = do_write & wr.strb[1];

	// lower lane carries the power state
	assign wr_lo = do_write & wr.strb[0];

	// per register, per lane write strobes
	assign cap_wr = wr_hi & hit_cap;
	assign csr_hi_wr = wr_hi & hit_csr;
	assign csr_lo_wr = wr_lo & hit_csr;

	// held from the take until the write is done
	assign aw_held_next = (st_ff.aw_held | aw_take) & ~do_write;

	// same for the data half
	assign w_held_next = (st_ff.w_held | w_take) & ~do_write;

	// answer stands until the master takes it
	assign bvalid_next = (st_ff.bvalid & ~b_done) | do_write;

	// read index of the byte address
	assign ar_idx = s_axi_araddr[11:2];

	// a read is taken whenever no answer is pending
	assign ar_take = s_axi_arvalid & st_ff.ar_open;

	// read answer accepted by the master
	assign r_done = st_ff.rvalid & s_axi_rready;

	// decode of the read index
	assign ar_hit_cap = ar_idx == `PMCAP_IDX_CAP;
	assign ar_hit_csr = ar_idx == `PMCAP_IDX_CSR;

	// read answer stands until taken
	assign rvalid_next = ar_take | (st_ff.rvalid & ~r_done);

	// unmapped reads return zero with an error answer
	always_comb begin
		rd_word = 32'h00000000;
		rd_resp = `PMCAP_RESP_OKAY;
		if (ar_hit_cap) begin
			rd_word = {16'h0000, cap_word};
		end else if (ar_hit_csr) begin
			rd_word = {16'h0000, csr_word};
		end else begin
			rd_resp = `PMCAP_RESP_SLVERR;
		end
	end

	// requested power state from the lower lane
	assign new_ps = pmcap_pstate_e'(wr.data[1:0]);

	// leaving D3hot for D0 asks for the internal reset
	assign from_d3hot = st_ff.power_state_field == PMCAP_D3HOT;
	assign to_d0 = new_ps == PMCAP_D0;
	assign d3hot_exit = csr_lo_wr & from_d3hot & to_d0;

	// card reset level, high while asserted
	assign card_rst = ~card_bus_reset_n;

	// no pulse while the card reset holds
	assign pulse_next = d3hot_exit & ~card_rst;

	// cold wake support, cleared by firmware without aux supply
	assign cold_next = cap_wr ? wr.data[`PMCAP_CAP_COLD_BIT] :
		st_ff.cold_wake_cap;

	// enable is left alone by the card reset
	assign en_next = csr_hi_wr ? wr.data[`PMCAP_CSR_EN_BIT] :
		st_ff.wake_enable;

	// any state code is accepted
	assign ps_written = csr_lo_wr ? new_ps : st_ff.power_state_field;

	// card reset returns the function to D0
	assign ps_next = card_rst ? PMCAP_D0 : ps_written;

	// only a one in the status bit clears it
	assign stat_clr = csr_hi_wr & wr.data[`PMCAP_CSR_STAT_BIT];

	// card reset drops wake context unless wake is enabled
	assign stat_kept = st_ff.wake_status_flag & ~stat_clr &
		~(card_rst & ~st_ff.wake_enable);

	// a new event wins over a clear in the same cycle
	assign stat_next = stat_kept | wake_event;

	// wake is driven only while flagged and enabled
	assign wake_drive = stat_next & en_next;

	always_comb begin
		nxt_st = st_ff;

		// write address and data are taken in either order
		nxt_st.aw_held = aw_held_next;
		nxt_st.w_held = w_held_next;
		if (aw_take) begin
			nxt_st.aw_idx = s_axi_awaddr[11:2];
		end
		if (w_take) begin
			nxt_st.wdata = s_axi_wdata[15:0];
			nxt_st.wstrb = s_axi_wstrb[1:0];
		end

		// write answer
		nxt_st.bvalid = bvalid_next;
		if (do_write) begin
			nxt_st.bresp = wr_resp;
		end

		// read answer, held still while it stands
		nxt_st.rvalid = rvalid_next;
		if (ar_take) begin
			nxt_st.rdata = rd_word;
			nxt_st.rresp = rd_resp;
		end

		// capability bit kept across both resets but the global one
		nxt_st.cold_wake_cap = cold_next;

		// the csr itself is untouched by the internal reset
		nxt_st.wake_enable = en_next;
		nxt_st.power_state_field = ps_next;
		nxt_st.wake_status_flag = stat_next;

		// one-cycle internal reset request
		nxt_st.func_reset = pulse_next;

		// wake pin, active low
		nxt_st.wake_n = ~wake_drive;

		// ready outputs come from flops, one per channel
		nxt_st.aw_open = ~aw_held_next;
		nxt_st.w_open = ~w_held_next;
		nxt_st.ar_open = ~rvalid_next;
	end

	// global reset clears all but the fixed defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.power_state_field <= PMCAP_D0;
			st_ff.wake_enable <= 1'b0;
			st_ff.cold_wake_cap <= `PMCAP_COLD_RESET;
			st_ff.wake_n <= 1'b1;
			st_ff.aw_open <= 1'b1;
			st_ff.w_open <= 1'b1;
			st_ff.ar_open <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// write channel
	assign s_axi_awready = st_ff.aw_open;
	assign s_axi_wready = st_ff.w_open;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;

	// read channel
	assign s_axi_arready = st_ff.ar_open;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	// function side
	assign power_state = st_ff.power_state_field;
	assign wake_n = st_ff.wake_n;
	assign func_reset_pulse = st_ff.func_reset;

endmodule

/* File: testbench/pmcap_regs_checker.sv */
// port-level checks on the power-management register bank
// assumes it is bound onto pmcap_regs, one clock, aresetn global
`timescale 1ns/1ps
module pmcap_regs_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic card_bus_reset_n,
	input wire logic wake_event,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] power_state,
	input wire logic wake_n,
	input wire logic func_reset_pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_pulse_single: assert property (
		func_reset_pulse |=> !func_reset_pulse) else $error("pulse long");
	a_pulse_cause: assert property (
		func_reset_pulse |-> power_state == 2'h0 && $past(power_state) == 2'h3)
		else $error("pulse without d3hot exit");
	a_card_d0: assert property (
		!card_bus_reset_n |=> power_state == 2'h0) else $error("card reset");
	a_state_cause: assert property (
		$changed(power_state) |-> $rose(s_axi_bvalid) || !$past(card_bus_reset_n))
		else $error("state changed alone");
	a_wake_release: assert property (
		$rose(wake_n) |-> $rose(s_axi_bvalid)) else $error("wake released");
	a_wake_drop: assert property (
		$fell(wake_n) |-> $past(wake_event) || $rose(s_axi_bvalid))
		else $error("wake without cause");
	a_read_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper bits");
	a_read_stable: assert property (
		s_axi_rvalid && $past(s_axi_rvalid) |-> $stable(s_axi_rdata))
		else $error("read data moved");
endmodule

bind pmcap_regs pmcap_regs_checker u_chk (.*);

/* File: testbench/pmcap_wake_src.sv */
// wake source standing in for the function's own wake logic
// assumes fire is driven by the bench just after a clock edge
`timescale 1ns/1ps
module pmcap_wake_src (
	input wire logic aclk,
	input wire logic fire,
	output logic wake_event
);
	initial wake_event = 1'h0;
	always @(posedge aclk) wake_event <= fire;
endmodule

/* File: testbench/pmcap_regs_test.sv */
// scenarios for the power-management register bank
// assumes the wake source model and an AXI4-Lite host in this bench
`timescale 1ns/1ps
`include "pmcap_cfg.svh"
module pmcap_regs_test;
	localparam logic [11:0] CAP = {`PMCAP_IDX_CAP, 2'h0};
	localparam logic [11:0] CSR = {`PMCAP_IDX_CSR, 2'h0};
	logic aclk = 1'h0, aresetn = 1'h0, card_bus_reset_n = 1'h1, fire = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wake_event, wake_n;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, func_reset_pulse;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic [1:0] s_axi_bresp, s_axi_rresp, power_state;
	int error_cnt = 0, n_checks = 0, pulses = 0;
	pmcap_regs u_dut (.*);
	pmcap_wake_src u_src (.*);
	initial forever #4 aclk = ~aclk;
	always @(posedge aclk) if (func_reset_pulse === 1'h1) pulses++;
	task automatic chk(input string n, input logic [31:0] s, x);
		n_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, logic [15:0] d, logic [1:0] e);
		@(posedge aclk) s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk) if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", s_axi_bresp, e);
	endtask
	task automatic rd(input logic [11:0] a, logic [15:0] x, logic [1:0] e);
		@(posedge aclk) s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk) if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", s_axi_rdata, {16'h0, x});
		chk("rresp", s_axi_rresp, e);
	endtask
	task automatic wake;
		@(posedge aclk) fire <= 1'h1;
		@(posedge aclk) fire <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic t_id;
		rd(CAP, 16'hfe12, 2'h0);
		rd(CSR, 16'h0000, 2'h0);
		wr(CAP, 16'h0000, 2'h0);
		rd(CAP, 16'h7e02, 2'h0);
		wr(CAP, 16'h8000, 2'h0);
		rd(CAP, 16'hfe12, 2'h0);
	endtask
	task automatic t_ps;
		for (int i = 0; i < 4; i++) begin
			wr(CSR, 16'(i), 2'h0);
			rd(CSR, 16'(i), 2'h0);
			chk("power_state", power_state, i);
		end
		wr(CSR, 16'h0100, 2'h0);
		rd(CSR, 16'h0100, 2'h0);
		chk("pulses", pulses, 1);
	endtask
	task automatic t_wake;
		wake;
		chk("wake_n", wake_n, 1'h0);
		rd(CSR, 16'h8100, 2'h0);
		wr(CSR, 16'h0100, 2'h0);
		rd(CSR, 16'h8100, 2'h0);
		wr(CSR, 16'h8000, 2'h0);
		rd(CSR, 16'h0000, 2'h0);
		chk("wake_n", wake_n, 1'h1);
		wake;
		rd(CSR, 16'h8000, 2'h0);
		chk("wake_n", wake_n, 1'h1);
		wr(CSR, 16'h8000, 2'h0);
	endtask
	task automatic t_card;
		wr(CSR, 16'h0102, 2'h0);
		wake;
		card_bus_reset_n <= 1'h0;
		repeat (2) @(posedge aclk);
		card_bus_reset_n <= 1'h1;
		chk("power_state", power_state, 2'h0);
		rd(CSR, 16'h8100, 2'h0);
		chk("wake_n", wake_n, 1'h0);
		wr(CSR, 16'h8000, 2'h0);
		wr(12'h000, 16'hffff, 2'h2);
		rd(12'h000, 16'h0000, 2'h2);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100us;
		error_cnt++;
		close_out;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_id;
		t_ps;
		t_wake;
		t_card;
		close_out;
	end
endmodule
